// >>> bench/bfb_host.sv
// host model driving the register write and read ports
`timescale 1ns/1ns
`default_nettype none
module bfb_host (
   input  wire logic       i_clk_sys,
   input  wire logic [1:0] i_busy,
   input  wire logic [5:0] i_rd_data,
   output logic            o_wr_stb,
   output logic      [7:0] o_wr_addr,
   output logic      [5:0] o_wr_data,
   output logic      [7:0] o_rd_addr
);
   initial begin
      o_wr_stb = 1'b0;
      o_wr_addr = 8'h00;
      o_wr_data = 6'h00;
      o_rd_addr = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [5:0] d);
      int n = 0;
      // a level is not retargeted while its bank still ramps, unless that wait runs past 5000 cycles
      while (n < 5000 && ((a == 8'h01 && i_busy[0]) || (a == 8'h02 && i_busy[1]))) begin
         @(negedge i_clk_sys);
         n++;
      end
      @(negedge i_clk_sys);
      o_wr_stb = 1'b1;
      o_wr_addr = a;
      o_wr_data = d;
      @(negedge i_clk_sys);
      o_wr_stb = 1'b0;
      o_wr_data = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [5:0] d);
      @(negedge i_clk_sys);
      o_rd_addr = a;
      @(negedge i_clk_sys);
      d = i_rd_data;
   endtask : rd
endmodule : bfb_host
`default_nettype wire

// >>> bench/bfb_top_assertions.sv
// concurrent checks on the backlight fade and bank block ports
`timescale 1ns/1ns
`default_nettype none
module bfb_chk #(
   parameter int P_TICK_CYCLES = 10
) (
   input wire logic       i_clk_sys,
   input wire logic       i_rst_b,
   input wire logic       i_wr_stb,
   input wire logic [7:0] i_wr_addr,
   input wire logic [5:0] i_wr_data,
   input wire logic [7:0] i_rd_addr,
   input wire logic [5:0] o_rd_data,
   input wire logic [4:0] o_sink_code_1,
   input wire logic [4:0] o_sink_code_2,
   input wire logic [4:0] o_sink_code_3,
   input wire logic [4:0] o_sink_code_4,
   input wire logic [4:0] o_sink_code_5,
   input wire logic [4:0] o_sink_code_6,
   input wire logic [5:0] o_sink_main,
   input wire logic       o_main_fading,
   input wire logic       o_sub_fading
);
   logic [5:0] fc_q;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) fc_q <= 6'h00;
      else if (i_wr_stb && i_wr_addr == 8'h09) fc_q <= i_wr_data;
   end
   function automatic logic [5:0] map_f(input logic [5:0] d);
      return (d[2:0] < 3'h6) ? (6'h3f >> d[2:0]) : 6'h3f;
   endfunction : map_f
   sequence s_fc_wr;
      i_wr_stb && i_wr_addr == 8'h09;
   endsequence
   sequence s_busy3(b);
      b && $past(b) && $past(b, 2);
   endsequence
   // sink 1 always sits in the main bank, sink 6 only sometimes in the sub bank
   chk_main_step: assert property (s_busy3(o_main_fading) |->
      5'(o_sink_code_1 - $past(o_sink_code_1)) inside {5'h00, 5'h01, 5'h1f})
      else $error("main code moved more than one count");
   chk_sub_step: assert property (s_busy3(o_sub_fading && !o_sink_main[5]) |->
      5'(o_sink_code_6 - $past(o_sink_code_6)) inside {5'h00, 5'h01, 5'h1f})
      else $error("sub code moved more than one count");
   chk_main_idle: assert property (!fc_q[0] && $past(!fc_q[0]) |=> !o_main_fading)
      else $error("main ramps while disabled");
   chk_sub_idle: assert property (!fc_q[3] && $past(!fc_q[3]) |=> !o_sub_fading)
      else $error("sub ramps while disabled");
   chk_cancel_apply: assert property (((o_main_fading && !i_wr_data[0]) and s_fc_wr) |->
      ##4 (!o_main_fading && $stable(o_sink_code_1))) else $error("cancel did not settle");
   chk_bank_map: assert property (i_wr_stb && i_wr_addr == 8'h0a |->
      ##3 o_sink_main == map_f($past(i_wr_data, 3))) else $error("bank map wrong");
   chk_bank_upper: assert property (i_rd_addr == 8'h0a |=> o_rd_data[5:3] == 3'h0)
      else $error("bank upper bits not zero");
   chk_fc_readback: assert property (s_fc_wr ##2 i_rd_addr == 8'h09 |=>
      o_rd_data == $past(i_wr_data, 3)) else $error("fade control readback wrong");
   chk_rd_unmapped: assert property (!(i_rd_addr inside {8'h01, 8'h02, [8'h09:8'h0d]}) |=>
      o_rd_data == 6'h00) else $error("unmapped read not zero");
endmodule : bfb_chk
bind bfb_top bfb_chk #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_chk (
   .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_wr_stb(i_wr_stb), .i_wr_addr(i_wr_addr),
   .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
   .o_sink_code_1(o_sink_code_1), .o_sink_code_2(o_sink_code_2), .o_sink_code_3(o_sink_code_3),
   .o_sink_code_4(o_sink_code_4), .o_sink_code_5(o_sink_code_5), .o_sink_code_6(o_sink_code_6),
   .o_sink_main(o_sink_main), .o_main_fading(o_main_fading), .o_sub_fading(o_sub_fading));
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the backlight fade and bank block
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int TICK = 10;
   logic       i_clk_sys = 1'b0;
   logic       i_rst_b = 1'b0;
   logic       wr_stb;
   logic [7:0] wr_addr;
   logic [7:0] rd_addr;
   logic [5:0] wr_data;
   logic [5:0] rd_data;
   logic [5:0] sink_main;
   logic [4:0] sk [6];
   logic [4:0] lvl [2];
   logic       main_fading;
   logic       sub_fading;
   int         err_total = 0;
   int         check_count = 0;
   always #5 i_clk_sys = ~i_clk_sys;
   bfb_top #(.P_TICK_CYCLES(TICK)) uut (
      .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_wr_stb(wr_stb), .i_wr_addr(wr_addr),
      .i_wr_data(wr_data), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
      .o_sink_code_1(sk[0]), .o_sink_code_2(sk[1]), .o_sink_code_3(sk[2]),
      .o_sink_code_4(sk[3]), .o_sink_code_5(sk[4]), .o_sink_code_6(sk[5]),
      .o_sink_main(sink_main), .o_main_fading(main_fading), .o_sub_fading(sub_fading));
   bfb_host host (
      .i_clk_sys(i_clk_sys), .i_busy({sub_fading, main_fading}), .i_rd_data(rd_data),
      .o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [5:0] d;
      host.rd(a, d);
      chk("rd_data", {2'b00, d}, exp);
   endtask : rdchk
   function automatic logic [5:0] fc_val(input int b, input int r, input logic en);
      return (b == 0) ? {3'h0, r[1:0], en} : {r[1:0], en, 3'h0};
   endfunction : fc_val
   // counts from the level write until both ramps report done
   task automatic wait_idle(output int cyc);
      cyc = 0;
      while (cyc < 4000 && (cyc < 4 || main_fading || sub_fading)) begin
         @(negedge i_clk_sys);
         cyc++;
      end
   endtask : wait_idle
   task automatic complete_run;
      if (err_total == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : complete_run
   initial begin : main_seq
      int cyc;
      int ms;
      logic [4:0] t;
      logic [5:0] m;
      repeat (3) @(negedge i_clk_sys);
      i_rst_b = 1'b1;
      chk("sink_main", {2'b00, sink_main}, 8'h3f);
      rdchk(8'h09, 8'h00);
      rdchk(8'h0a, 8'h06);
      host.wr(8'h0a, 6'h3f);
      rdchk(8'h0a, 8'h07);
      lvl[0] = 5'h0a;
      lvl[1] = 5'h14;
      host.wr(8'h01, {1'b0, lvl[0]});
      host.wr(8'h02, {1'b0, lvl[1]});
      for (int c = 0; c < 8; c++) begin
         host.wr(8'h0a, 6'(c));
         repeat (3) @(negedge i_clk_sys);
         m = (c < 6) ? (6'h3f >> c) : 6'h3f;
         chk("sink_main", {2'b00, sink_main}, {2'b00, m});
         for (int s = 0; s < 6; s++)
            chk("sink_code", {3'b000, sk[s]}, {3'b000, m[s] ? lvl[0] : lvl[1]});
      end
      host.wr(8'h0a, 6'h03);
      for (int b = 0; b < 2; b++) begin
         for (int r = 0; r < 4; r++) begin
            ms = 32 - 8 * r;
            t = r[0] ? lvl[b] - 5'h02 : lvl[b] + 5'h02;
            host.wr(8'h09, fc_val(b, r, 1'b1));
            host.wr(8'h01 + 8'(b), {1'b0, t});
            wait_idle(cyc);
            lvl[b] = t;
            chk("fade_cycles", 8'(cyc >= (2 * ms - 1) * TICK - 2 && cyc <= 2 * ms * TICK + 6), 8'h01);
            chk("sink_code", {3'b000, sk[b * 5]}, {3'b000, t});
         end
      end
      for (int b = 0; b < 2; b++) begin
         t = b ? lvl[b] - 5'h08 : lvl[b] + 5'h08;
         host.wr(8'h09, fc_val(b, 0, 1'b1));
         host.wr(8'h01 + 8'(b), {1'b0, t});
         repeat (500) @(negedge i_clk_sys);
         chk("fading", {7'h00, b ? sub_fading : main_fading}, 8'h01);
         rdchk(8'h0b, 8'h01 << b);
         host.wr(8'h09, fc_val(b, 0, 1'b0));
         repeat (3) @(negedge i_clk_sys);
         chk("sink_code", {3'b000, sk[b * 5]}, {3'b000, t});
         lvl[b] = t + 5'h04;
         host.wr(8'h09, fc_val(b, 0, 1'b1));
         host.wr(8'h01 + 8'(b), {1'b0, lvl[b]});
         repeat (100) @(negedge i_clk_sys);
         host.wr(8'h09, fc_val(b, 3, 1'b1));
         rdchk(8'h09, {2'b00, fc_val(b, 3, 1'b1)});
         wait_idle(cyc);
         // four steps at the slow rate would need well over this bound
         chk("fade_cycles", 8'(cyc <= 4 * 8 * TICK + TICK + 6), 8'h01);
         chk("sink_code", {3'b000, sk[b * 5]}, {3'b000, lvl[b]});
         rdchk(8'h0c + 8'(b), {3'b000, lvl[b]});
      end
      complete_run();
   end
   initial begin : watchdog
      repeat (20000) @(posedge i_clk_sys);
      err_total++;
      complete_run();
   end
endmodule : tb
`default_nettype wire

// >>> core/bfb_fade_ramp.sv
// one bank's level ramp toward its written target
`timescale 1ns/1ns
`default_nettype none
module bfb_fade_ramp (
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_rst_b,
   input  wire logic                       i_tick,
   input  wire logic                       i_enable,
   input  wire logic [bfb_pkg::RATE_W-1:0] i_rate,
   input  wire logic [bfb_pkg::LVL_W-1:0]  i_target,
   output logic      [bfb_pkg::LVL_W-1:0]  o_level,
   output logic                            o_busy
);
   logic [bfb_pkg::MS_W-1:0] ms_reg;
   logic [bfb_pkg::MS_W-1:0] interval;
   logic [bfb_pkg::MS_W-1:0] ms_next;

   // interval follows the live rate field, so a mid-fade change steers the next step
   always_comb begin
      unique case (i_rate)
         2'h0: interval = bfb_pkg::RATE_MS_0;
         2'h1: interval = bfb_pkg::RATE_MS_1;
         2'h2: interval = bfb_pkg::RATE_MS_2;
         2'h3: interval = bfb_pkg::RATE_MS_3;
      endcase
   end

   assign ms_next = ms_reg + 1'b1;
   assign o_busy  = i_enable && (o_level != i_target);

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_level <= bfb_pkg::LEVEL_RST;
         ms_reg  <= '0;
      end else if (!i_enable) begin
         // disabled or cancelled: applied code jumps straight to the stored one
         o_level <= i_target;
         ms_reg  <= '0;
      end else if (o_level == i_target) begin
         ms_reg  <= '0;
      end else if (i_tick) begin
         // >= lets a shortened rate take effect without waiting a wrap
         if (ms_next >= interval) begin
            ms_reg <= '0;
            if (o_level < i_target) begin
               o_level <= o_level + 1'b1;
            end else begin
               o_level <= o_level - 1'b1;
            end
         end else begin
            ms_reg <= ms_next;
         end
      end
   end
endmodule : bfb_fade_ramp
`default_nettype wire

// >>> core/bfb_ms_tick.sv
// free-running millisecond tick generator
`timescale 1ns/1ns
`default_nettype none
module bfb_ms_tick #(
   parameter int P_TICK_CYCLES = bfb_pkg::TICK_CYCLES
) (
   input  wire logic i_clk_sys,
   input  wire logic i_rst_b,
   output logic      o_tick
);
   logic [bfb_pkg::TICK_CNT_W-1:0] cnt_reg;
   logic                           wrap;

   assign wrap = (cnt_reg == bfb_pkg::TICK_CNT_W'(P_TICK_CYCLES - 1));

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_reg <= '0;
         o_tick  <= 1'b0;
      end else begin
         cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
         o_tick  <= wrap;
      end
   end
endmodule : bfb_ms_tick
`default_nettype wire

// >>> core/bfb_pkg.sv
// constants for the backlight fade and bank control block
package bfb_pkg;
   // register access widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 6;
   localparam int LVL_W  = 5;
   localparam int SINKS  = 6;
   localparam int BANK_W = 3;
   localparam int RATE_W = 2;
   localparam int MS_W   = 6;

   // register offsets
   localparam logic [ADDR_W-1:0] ADDR_MAIN_LEVEL = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_SUB_LEVEL  = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_FADE_CTRL  = 8'h09;
   localparam logic [ADDR_W-1:0] ADDR_BANK_SEL   = 8'h0a;
   localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h0b;
   localparam logic [ADDR_W-1:0] ADDR_MAIN_NOW   = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_SUB_NOW    = 8'h0d;

   // fade control fields
   localparam int FC_MAIN_EN   = 0;
   localparam int FC_MAIN_RATE = 1;
   localparam int FC_SUB_EN    = 3;
   localparam int FC_SUB_RATE  = 4;

   // status fields
   localparam int ST_MAIN_BUSY = 0;
   localparam int ST_SUB_BUSY  = 1;

   // reset values
   localparam logic [DATA_W-1:0] FADE_CTRL_RST  = 6'h00;
   localparam logic [BANK_W-1:0] BANK_SEL_RST   = 3'h6;
   localparam logic [LVL_W-1:0]  LEVEL_RST      = 5'h00;

   // step intervals in ms per rate code
   localparam logic [MS_W-1:0] RATE_MS_0 = 6'h20;
   localparam logic [MS_W-1:0] RATE_MS_1 = 6'h18;
   localparam logic [MS_W-1:0] RATE_MS_2 = 6'h10;
   localparam logic [MS_W-1:0] RATE_MS_3 = 6'h08;

   // millisecond time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS       = 1000000;
   localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
   localparam int TICK_CNT_W    = 17;
endpackage : bfb_pkg

// >>> core/bfb_top.sv
// register file, bank ramps and sink assignment for the backlight block
`timescale 1ns/1ns
`default_nettype none
// Operation
// - main rate code picks 32/24/16/8 ms
// - sub rate code picks 32/24/16/8 ms
// - main fades only while main enable set
// - sub fades only while sub enable set
// - main step count equals code difference
// - sub step count equals code difference
// - enabled main ramps one step per interval
// - enabled sub ramps one step per interval
// - clearing main enable applies stored code
// - clearing sub enable applies stored code
// - main disabled means level applies instantly
// - sub disabled means level applies instantly
// - main rate change honoured mid-fade
// - sub rate change honoured mid-fade
// - bank code sets sinks main; 6,7 all
// - unassigned sinks follow sub bank
// - bank register upper bits read zero
// - sub level is five bits at 02h
module bfb_top #(
   parameter int P_TICK_CYCLES = bfb_pkg::TICK_CYCLES
) (
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_rst_b,
   input  wire logic                       i_wr_stb,
   input  wire logic [bfb_pkg::ADDR_W-1:0] i_wr_addr,
   input  wire logic [bfb_pkg::DATA_W-1:0] i_wr_data,
   input  wire logic [bfb_pkg::ADDR_W-1:0] i_rd_addr,
   output logic      [bfb_pkg::DATA_W-1:0] o_rd_data,
   output logic      [bfb_pkg::LVL_W-1:0]  o_sink_code_1,
   output logic      [bfb_pkg::LVL_W-1:0]  o_sink_code_2,
   output logic      [bfb_pkg::LVL_W-1:0]  o_sink_code_3,
   output logic      [bfb_pkg::LVL_W-1:0]  o_sink_code_4,
   output logic      [bfb_pkg::LVL_W-1:0]  o_sink_code_5,
   output logic      [bfb_pkg::LVL_W-1:0]  o_sink_code_6,
   output logic      [bfb_pkg::SINKS-1:0]  o_sink_main,
   output logic                            o_main_fading,
   output logic                            o_sub_fading
);
   // software-visible registers
   logic [bfb_pkg::LVL_W-1:0]  main_level_code_reg;
   logic [bfb_pkg::LVL_W-1:0]  sub_level_code_reg;
   logic [bfb_pkg::DATA_W-1:0] fade_control_reg;
   logic [bfb_pkg::BANK_W-1:0] bank_selection_reg;

   // decoded fade control fields
   logic                       main_ramp_enable;
   logic                       sub_ramp_enable;
   logic [bfb_pkg::RATE_W-1:0] main_rate;
   logic [bfb_pkg::RATE_W-1:0] sub_rate;

   // ramp outputs
   logic                       ms_tick;
   logic [bfb_pkg::LVL_W-1:0]  main_applied;
   logic [bfb_pkg::LVL_W-1:0]  sub_applied;
   logic                       main_busy;
   logic                       sub_busy;

   // sink mapping
   logic [bfb_pkg::SINKS-1:0]  sink_main_next;
   logic [bfb_pkg::LVL_W-1:0]  sink_code_reg [bfb_pkg::SINKS];
   logic [bfb_pkg::DATA_W-1:0] rd_data_next;

   // write decode
   logic wr_main_level;
   logic wr_sub_level;
   logic wr_fade_ctrl;
   logic wr_bank_sel;

   assign wr_main_level = i_wr_stb && (i_wr_addr == bfb_pkg::ADDR_MAIN_LEVEL);
   assign wr_sub_level  = i_wr_stb && (i_wr_addr == bfb_pkg::ADDR_SUB_LEVEL);
   assign wr_fade_ctrl  = i_wr_stb && (i_wr_addr == bfb_pkg::ADDR_FADE_CTRL);
   assign wr_bank_sel   = i_wr_stb && (i_wr_addr == bfb_pkg::ADDR_BANK_SEL);

   // level registers: the stored code is the target, the ramp owns the applied one
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         main_level_code_reg <= bfb_pkg::LEVEL_RST;
      end else if (wr_main_level) begin
         // a write mid-fade simply retargets; the host is expected not to do it
         main_level_code_reg <= i_wr_data[bfb_pkg::LVL_W-1:0];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sub_level_code_reg <= bfb_pkg::LEVEL_RST;
      end else if (wr_sub_level) begin
         // reserved codes 1..3 are stored as written; the analog side decides
         sub_level_code_reg <= i_wr_data[bfb_pkg::LVL_W-1:0];
      end
   end

   // fade control register
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fade_control_reg <= bfb_pkg::FADE_CTRL_RST;
      end else if (wr_fade_ctrl) begin
         fade_control_reg <= i_wr_data;
      end
   end

   assign main_ramp_enable = fade_control_reg[bfb_pkg::FC_MAIN_EN];
   assign sub_ramp_enable  = fade_control_reg[bfb_pkg::FC_SUB_EN];
   assign main_rate = fade_control_reg[bfb_pkg::FC_MAIN_RATE +: bfb_pkg::RATE_W];
   assign sub_rate  = fade_control_reg[bfb_pkg::FC_SUB_RATE +: bfb_pkg::RATE_W];

   // bank selection register
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bank_selection_reg <= bfb_pkg::BANK_SEL_RST;
      end else if (wr_bank_sel) begin
         // upper bits are not stored at all
         bank_selection_reg <= i_wr_data[bfb_pkg::BANK_W-1:0];
      end
   end

   // shared millisecond time base; one prescaler serves both banks
   bfb_ms_tick #(
      .P_TICK_CYCLES (P_TICK_CYCLES)
   ) u_ms_tick (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .o_tick    (ms_tick)
   );

   // per-bank ramps
   // main ramp: steps of one toward the target, live rate, cancel on enable clear
   bfb_fade_ramp u_main_ramp (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_tick    (ms_tick),
      .i_enable  (main_ramp_enable),
      .i_rate    (main_rate),
      .i_target  (main_level_code_reg),
      .o_level   (main_applied),
      .o_busy    (main_busy)
   );

   // sub ramp: same behaviour on the sub bank's own settings
   bfb_fade_ramp u_sub_ramp (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_tick    (ms_tick),
      .i_enable  (sub_ramp_enable),
      .i_rate    (sub_rate),
      .i_target  (sub_level_code_reg),
      .o_level   (sub_applied),
      .o_busy    (sub_busy)
   );

   // sink assignment: code n puts sinks 1..6-n on main, codes 6 and 7 put all
   always_comb begin
      sink_main_next = '0;
      for (int i = 0; i < bfb_pkg::SINKS; i++) begin
         if (bank_selection_reg >= bfb_pkg::BANK_W'(bfb_pkg::SINKS)) begin
            sink_main_next[i] = 1'b1;
         end else begin
            sink_main_next[i] = (i < (bfb_pkg::SINKS - int'(bank_selection_reg)));
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_sink_main <= '1;
      end else begin
         o_sink_main <= sink_main_next;
      end
   end

   // each sink drives the applied code of the bank that owns it
   generate
      for (genvar g = 0; g < bfb_pkg::SINKS; g++) begin : g_sink
         always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
            if (!i_rst_b) begin
               sink_code_reg[g] <= bfb_pkg::LEVEL_RST;
            end else if (sink_main_next[g]) begin
               sink_code_reg[g] <= main_applied;
            end else begin
               sink_code_reg[g] <= sub_applied;
            end
         end
      end
   endgenerate

   assign o_sink_code_1 = sink_code_reg[0];
   assign o_sink_code_2 = sink_code_reg[1];
   assign o_sink_code_3 = sink_code_reg[2];
   assign o_sink_code_4 = sink_code_reg[3];
   assign o_sink_code_5 = sink_code_reg[4];
   assign o_sink_code_6 = sink_code_reg[5];

   // fade status flags
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_main_fading <= 1'b0;
         o_sub_fading  <= 1'b0;
      end else begin
         o_main_fading <= main_busy;
         o_sub_fading  <= sub_busy;
      end
   end

   // read-back; unmapped offsets read zero, data lags the address by one cycle
   always_comb begin
      rd_data_next = '0;
      unique case (i_rd_addr)
         bfb_pkg::ADDR_MAIN_LEVEL: begin
            rd_data_next[bfb_pkg::LVL_W-1:0] = main_level_code_reg;
         end
         bfb_pkg::ADDR_SUB_LEVEL: begin
            rd_data_next[bfb_pkg::LVL_W-1:0] = sub_level_code_reg;
         end
         bfb_pkg::ADDR_FADE_CTRL: begin
            rd_data_next = fade_control_reg;
         end
         bfb_pkg::ADDR_BANK_SEL: begin
            rd_data_next[bfb_pkg::BANK_W-1:0] = bank_selection_reg;
         end
         bfb_pkg::ADDR_STATUS: begin
            rd_data_next[bfb_pkg::ST_MAIN_BUSY] = main_busy;
            rd_data_next[bfb_pkg::ST_SUB_BUSY]  = sub_busy;
         end
         bfb_pkg::ADDR_MAIN_NOW: begin
            rd_data_next[bfb_pkg::LVL_W-1:0] = main_applied;
         end
         bfb_pkg::ADDR_SUB_NOW: begin
            rd_data_next[bfb_pkg::LVL_W-1:0] = sub_applied;
         end
         default: begin
            rd_data_next = '0;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rd_data <= '0;
      end else begin
         o_rd_data <= rd_data_next;
      end
   end
endmodule : bfb_top
`default_nettype wire
